// file: rtl/crpc_pkg.sv
package crpc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned RELEASE_CYCLES  = 32;     // Default release delay, internal clocks
    localparam int unsigned POR_CYCLES      = 16;     // Default power-on reset stretch
    localparam int unsigned CNT_W           = 16;     // Width of the delay counters

    // ------------------------------------------------------------
    // Pull-up disable register layout
    // ------------------------------------------------------------
    localparam int unsigned PUDR_W          = 8;      // Width of the disable register image
    localparam int unsigned PUDR_RESET_BIT  = 0;      // Bit that turns off the reset pin pull-up
    localparam int unsigned PUDR_STRAP_BIT  = 1;      // Bit that turns off the strap pull-up
    localparam logic [7:0]  PUDR_RESET_VAL  = 8'h00;  // All pull-ups on after reset

    // ------------------------------------------------------------
    // Boot modes
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        CRPC_BOOT_INTERNAL = 1'b0,                    // Strap low: boot from on-chip memory
        CRPC_BOOT_EXTERNAL = 1'b1                     // Strap high: boot from off-chip memory
    } crpc_boot_type;

    // Sequencer states
    typedef enum logic [1:0] {
        CRPC_ST_HOLD    = 2'b00,                      // Reset asserted
        CRPC_ST_COUNT   = 2'b01,                      // Counting release delay
        CRPC_ST_RUN     = 2'b10                       // Internal reset released
    } crpc_state_type;

    // Status bundle toward the chip core
    typedef struct packed {
        logic          chip_rst_n;                    // Internal reset, active low
        logic          mode_valid;                    // Boot mode has been latched
        crpc_boot_type boot_mode;                     // Latched boot mode
    } crpc_status_type;

endpackage : crpc_pkg

// file: rtl/crpc_por.sv
`timescale 1ns/1ns
// Power-on reset generator: holds por_n low for a fixed count after power-up.
module crpc_por #(
    parameter int unsigned CYCLES = crpc_pkg::POR_CYCLES
) (
    // Clock
    input  wire logic clk_in,
    // Power-up indicator, high until supply is good
    input  wire logic pwr_good_n_in,
    // Result
    output logic      por_n_out
);
    localparam logic [crpc_pkg::CNT_W-1:0] CRPC_LAST = crpc_pkg::CNT_W'(CYCLES - 1);

    logic [crpc_pkg::CNT_W-1:0] cnt_r;                // Stretch counter
    logic                       done_r;               // Stretch finished
    logic                       good_s1_r;            // Supply-good sync, first stage
    logic                       good_s2_r;            // Supply-good sync, read by the counter

    // ------------------------------------------------------------
    // Supply-good release through two flops
    // ------------------------------------------------------------
    // The monitor is not on this clock; a raw release could start
    // the count in a metastable cycle
    always_ff @(posedge clk_in or posedge pwr_good_n_in) begin
        if (pwr_good_n_in) begin
            good_s1_r <= 1'b0;
            good_s2_r <= 1'b0;
        end else begin
            good_s1_r <= 1'b1;
            good_s2_r <= good_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Stretch counter; only a supply drop restarts it, never the pin
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge pwr_good_n_in) begin
        if (pwr_good_n_in) begin
            cnt_r  <= '0;
            done_r <= 1'b0;
        end else if (good_s2_r && !done_r) begin
            cnt_r  <= cnt_r + 1'b1;
            done_r <= (cnt_r == CRPC_LAST);
        end
    end

    assign por_n_out = done_r;

    // Power-on reset must persist the full stretch
    AST_POR_HOLD: assert property (@(posedge clk_in) disable iff (pwr_good_n_in) // RQ6
        $rose(por_n_out) |-> $past(cnt_r) == CRPC_LAST)
        else $error("power-on reset released early");

endmodule : crpc_por

// file: rtl/crpc_top.sv
`timescale 1ns/1ns
// What this block does
// RQ1: Low reset pin initializes and holds everything; the strap synchroniser and power-on stretch counter are not reset by it
// RQ2: Latch boot strap on reset release
// RQ3: Release internal reset synchronously after count
// RQ4: Board asserts reset and TRST together; board model leaves TRST idle when debug_only_in is high
// RQ5: Reset alone leaves debug logic untouched
// RQ6: Power-on reset asserts regardless of pin
// RQ7: Reset pin pull-up on unless disabled
// RQ8: Reset output mirrors internal reset state
// RQ9: Board ties strap high for external boot
// RQ10: Async assert; release delay is parameter
module crpc_top #(
    parameter int unsigned RELEASE_CYCLES = crpc_pkg::RELEASE_CYCLES,
    parameter int unsigned POR_CYCLES     = crpc_pkg::POR_CYCLES
) (
    // Clock and external reset pin
    input  wire logic                          CLK_IN,
    input  wire logic                          RSTN_IN,
    // Supply monitor, high until power is good
    input  wire logic                          PWR_GOOD_N_IN,
    // Boot strap pin
    input  wire logic                          BOOT_SOURCE_STRAP_IN,
    // Pull-up disable register image from the system block
    input  wire logic [crpc_pkg::PUDR_W-1:0]   PULLUP_DISABLE_REGISTER_IN,
    // Pull-up enables toward the pads
    output logic                               RESET_PULLUP_EN_OUT,
    output logic                               STRAP_PULLUP_EN_OUT,
    // Internal reset and boot status toward the core
    output crpc_pkg::crpc_status_type          STATUS_OUT,
    // Reset output pin, active low
    output logic                               RESET_STATE_OUTPUT_N_OUT
);

    // ------------------------------------------------------------
    // Reset combining
    // ------------------------------------------------------------
    logic por_n;                                      // Power-on reset, active low
    logic any_rst_n;                                  // Pin or power-on reset, active low

    crpc_por #(
        .CYCLES        (POR_CYCLES)
    ) u_por (
        .clk_in        (CLK_IN),
        .pwr_good_n_in (PWR_GOOD_N_IN),
        .por_n_out     (por_n)
    );

    // Either source asserts with no clock needed
    assign any_rst_n = RSTN_IN & por_n; // RQ6

    // Reset copy released through two flops
    logic rst_s1_r;                                   // First stage, read only by second
    logic rst_s2_r;                                   // Synchronised reset, active low

    always_ff @(posedge CLK_IN or negedge any_rst_n) begin
        if (!any_rst_n) begin // RQ1
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Strap synchroniser; the pin is outside the clock domain
    // ------------------------------------------------------------
    logic strap_s1_r;                                 // First stage
    logic strap_s2_r;                                 // Stable strap level

    always_ff @(posedge CLK_IN) begin
        strap_s1_r <= BOOT_SOURCE_STRAP_IN;
        strap_s2_r <= strap_s1_r;
    end

    // ------------------------------------------------------------
    // Release sequencer
    // ------------------------------------------------------------
    // The boot mode is taken in the single HOLD cycle, so the core
    // sees a valid mode for the whole release delay; the price is
    // one extra cycle of reset after every release
    localparam logic [crpc_pkg::CNT_W-1:0] REL_LAST =
        crpc_pkg::CNT_W'(RELEASE_CYCLES - 1);

    crpc_pkg::crpc_state_type   state_r;              // Sequencer state
    crpc_pkg::crpc_state_type   state_nxt;            // Next state
    logic [crpc_pkg::CNT_W-1:0] cnt_r;                // Release delay counter
    logic                       cnt_done;             // Delay expired
    logic                       chip_rst_n_r;         // Internal reset, active low
    crpc_pkg::crpc_boot_type    boot_r;               // Latched boot mode
    logic                       mode_valid_r;         // Boot mode latched

    assign cnt_done = (cnt_r == REL_LAST);

    // Next state; hold while the synchronised reset is low
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            crpc_pkg::CRPC_ST_HOLD: begin
                state_nxt = crpc_pkg::CRPC_ST_COUNT;
            end
            crpc_pkg::CRPC_ST_COUNT: begin
                if (cnt_done) begin // RQ3
                    state_nxt = crpc_pkg::CRPC_ST_RUN;
                end
            end
            crpc_pkg::CRPC_ST_RUN: begin
                state_nxt = crpc_pkg::CRPC_ST_RUN;
            end
            default: begin
                state_nxt = crpc_pkg::CRPC_ST_HOLD;
            end
        endcase
    end

    // State register; async assert, counted release
    always_ff @(posedge CLK_IN or negedge rst_s2_r) begin
        if (!rst_s2_r) begin // RQ10
            state_r <= crpc_pkg::CRPC_ST_HOLD;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Delay counter runs only while counting
    always_ff @(posedge CLK_IN or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            cnt_r <= '0;
        end else if (state_r == crpc_pkg::CRPC_ST_COUNT && !cnt_done) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // Internal reset drops at once, rises on a clock edge
    always_ff @(posedge CLK_IN or negedge rst_s2_r) begin
        if (!rst_s2_r) begin // RQ10
            chip_rst_n_r <= 1'b0;
        end else begin
            chip_rst_n_r <= (state_nxt == crpc_pkg::CRPC_ST_RUN); // RQ3
        end
    end

    // Boot mode caught once, in the first cycle after release
    always_ff @(posedge CLK_IN or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            boot_r       <= crpc_pkg::CRPC_BOOT_INTERNAL;
            mode_valid_r <= 1'b0;
        end else if (state_r == crpc_pkg::CRPC_ST_HOLD) begin // RQ2
            boot_r       <= crpc_pkg::crpc_boot_type'(strap_s2_r);
            mode_valid_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Debug logic is not reset here; only TRST clears it
    assign STATUS_OUT = '{chip_rst_n: chip_rst_n_r,    // RQ5
                          mode_valid: mode_valid_r,
                          boot_mode:  boot_r};
    assign RESET_STATE_OUTPUT_N_OUT = chip_rst_n_r;    // RQ8

    // Pull-ups default on; the register image clears back to zero
    assign RESET_PULLUP_EN_OUT =
        ~PULLUP_DISABLE_REGISTER_IN[crpc_pkg::PUDR_RESET_BIT]; // RQ7
    assign STRAP_PULLUP_EN_OUT =
        ~PULLUP_DISABLE_REGISTER_IN[crpc_pkg::PUDR_STRAP_BIT];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_PIN_HOLDS: assert property (@(posedge CLK_IN) // RQ1
        !RSTN_IN |-> !RESET_STATE_OUTPUT_N_OUT)
        else $error("internal reset not held during pin reset");

    AST_RELEASE_DELAY: assert property (@(posedge CLK_IN) disable iff (!rst_s2_r) // RQ3
        $rose(chip_rst_n_r) |-> $past(state_r) == crpc_pkg::CRPC_ST_COUNT && $past(cnt_done))
        else $error("internal reset released before delay");

    AST_BOOT_LATCH: assert property (@(posedge CLK_IN) disable iff (!rst_s2_r) // RQ2
        $rose(mode_valid_r) |-> boot_r == crpc_pkg::crpc_boot_type'($past(strap_s2_r)))
        else $error("boot mode not taken from strap");

    AST_BOOT_STABLE: assert property (@(posedge CLK_IN) disable iff (!rst_s2_r) // RQ2
        $past(mode_valid_r) |-> $stable(boot_r))
        else $error("boot mode changed after latch");

    AST_OUT_MIRROR: assert property (@(posedge CLK_IN) // RQ8
        RESET_STATE_OUTPUT_N_OUT == (state_r == crpc_pkg::CRPC_ST_RUN))
        else $error("reset output differs from internal reset");

    AST_POR_ASSERTS: assert property (@(posedge CLK_IN) // RQ6
        !por_n |-> !chip_rst_n_r)
        else $error("internal reset free during power-on reset");

    AST_PULLUP: assert property (@(posedge CLK_IN) // RQ7
        RESET_PULLUP_EN_OUT != PULLUP_DISABLE_REGISTER_IN[crpc_pkg::PUDR_RESET_BIT])
        else $error("pull-up enable wrong");

    AST_NO_EARLY: assert property (@(posedge CLK_IN) disable iff (!rst_s2_r) // RQ10
        $rose(state_r == crpc_pkg::CRPC_ST_COUNT) |-> !chip_rst_n_r [*2])
        else $error("internal reset released without delay");

    // Internal reset and mode valid are cleared while either reset source is active
    AST_ASYNC_CLEAR: assert property (@(posedge CLK_IN) // RQ1
        !any_rst_n |-> !chip_rst_n_r && !mode_valid_r)
        else $error("state not cleared during reset");

    // The hold state lasts exactly one cycle before counting starts
    AST_HOLD_ONCE: assert property (@(posedge CLK_IN) disable iff (!rst_s2_r) // RQ3
        state_r == crpc_pkg::CRPC_ST_HOLD |=> state_r == crpc_pkg::CRPC_ST_COUNT)
        else $error("hold state not left after one cycle");

    // Once released, the reset output stays high until a new reset
    AST_RUN_STAYS: assert property (@(posedge CLK_IN) disable iff (!rst_s2_r) // RQ8
        RESET_STATE_OUTPUT_N_OUT |=> RESET_STATE_OUTPUT_N_OUT)
        else $error("reset output dropped without reset");

    // The core never leaves reset without a latched boot mode
    AST_MODE_FIRST: assert property (@(posedge CLK_IN) // RQ2
        STATUS_OUT.chip_rst_n |-> STATUS_OUT.mode_valid)
        else $error("reset released before boot mode latched");

endmodule : crpc_top

// file: testbench/crpc_board.sv
`timescale 1ns/1ns
// Board side: reset switch, debug probe and strap tie
module crpc_board (
    // Commands from the bench
    input  wire logic rst_req_in,     // Press the reset switch
    input  wire logic debug_only_in,  // Debugger keeps test reset idle
    input  wire logic pwr_bad_in,     // Supply not yet good
    input  wire logic strap_high_in,  // Strap tie choice
    // Pins toward the device
    output logic      rst_n_out,      // Push-pull, so no floating level
    output logic      trst_n_out,     // Test reset toward debug logic
    output logic      pwr_good_n_out,
    output logic      strap_out
);
    // Full reset pulls both lines; a debug reset leaves test reset idle
    assign rst_n_out      = ~rst_req_in;
    assign trst_n_out     = ~(rst_req_in & ~debug_only_in);
    assign pwr_good_n_out = pwr_bad_in;
    // Hard tie, high selects off-chip boot
    assign strap_out      = strap_high_in;
endmodule : crpc_board

// file: testbench/crpc_top_bench.sv
`timescale 1ns/1ns
module crpc_top_bench;
    // ------------------------------------------------------------
    // Shortened counts keep the run brief
    // ------------------------------------------------------------
    localparam int unsigned REL = 4;
    localparam int unsigned POR = 4;
    logic                     clk;
    logic                     rst_req, dbg, pwr_bad, strap_hi;
    logic [crpc_pkg::PUDR_W-1:0] pudr;
    logic                     rst_n, trst_n, pwr_good_n, strap;
    logic                     pu_rst, pu_strap, rst_pin_n;
    crpc_pkg::crpc_status_type st;
    int                       failures = 0;
    int                       compares = 0;

    crpc_board u_crpc_board (.rst_req_in(rst_req), .debug_only_in(dbg), .pwr_bad_in(pwr_bad),
        .strap_high_in(strap_hi), .rst_n_out(rst_n), .trst_n_out(trst_n),
        .pwr_good_n_out(pwr_good_n), .strap_out(strap));
    crpc_top #(.RELEASE_CYCLES(REL), .POR_CYCLES(POR)) u_crpc_top (.CLK_IN(clk),
        .RSTN_IN(rst_n), .PWR_GOOD_N_IN(pwr_good_n), .BOOT_SOURCE_STRAP_IN(strap),
        .PULLUP_DISABLE_REGISTER_IN(pudr), .RESET_PULLUP_EN_OUT(pu_rst),
        .STRAP_PULLUP_EN_OUT(pu_strap), .STATUS_OUT(st), .RESET_STATE_OUTPUT_N_OUT(rst_pin_n));

    // Clock, 40 ns period
    always #20 clk = ~clk;

    task automatic chk(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask : chk

    // Inputs move 2 ns after the edge so sampling never races
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step

    // Enables are plain inverses; upper bits must not matter
    task automatic t_pullup;
        for (int i = 0; i < 4; i++) begin
            pudr = 8'hFC | 8'(i);
            step(1);
            chk("pullup_rst", ~pudr[0], pu_rst);
            chk("pullup_strap", ~pudr[1], pu_strap);
        end
        pudr = crpc_pkg::PUDR_RESET_VAL;
    endtask : t_pullup

    // Hold, release, time the delay, then check the latched mode
    task automatic t_boot(input logic s);
        int n;
        strap_hi = s;
        rst_req  = 1'b1;
        step(2);
        chk("rst_hold", 1'b0, st.chip_rst_n);
        chk("mode_hold", 1'b0, st.mode_valid);
        chk("trst_hold", dbg, trst_n);
        rst_req = 1'b0;
        n = 0;
        while (st.chip_rst_n !== 1'b1 && n < 40) begin
            chk("reset_state_output_follow", 1'b0, rst_pin_n);
            step(1);
            n++;
        end
        chk("delay_min", 1'b1, n > REL);
        chk("delay_max", 1'b1, n <= REL + 4);
        chk("reset_state_output_high", 1'b1, rst_pin_n);
        chk("boot_mode", s, st.boot_mode);
        chk("mode_valid", 1'b1, st.mode_valid);
        strap_hi = ~s;
        step(4);
        chk("mode_kept", s, st.boot_mode);
    endtask : t_boot

    // Mid-cycle assert must act at once; reassert restarts the count
    task automatic t_async;
        rst_req = 1'b1;
        #1;
        chk("async_rst", 1'b0, st.chip_rst_n);
        chk("async_reset_state_output", 1'b0, rst_pin_n);
        step(1);
        rst_req = 1'b0;
        step(REL);
        rst_req = 1'b1;
        step(1);
        rst_req = 1'b0;
        step(REL + 1);
        chk("restart_low", 1'b0, st.chip_rst_n);
        step(8);
        chk("restart_done", 1'b1, st.chip_rst_n);
    endtask : t_async

    // Supply drop resets with the pin idle high
    task automatic t_por;
        pwr_bad = 1'b1;
        #1;
        chk("por_assert", 1'b0, st.chip_rst_n);
        step(3);
        pwr_bad = 1'b0;
        // Lands after the point where an unstretched reset would end
        step(POR + REL + 2);
        chk("por_stretch", 1'b0, st.chip_rst_n);
        step(8);
        chk("por_done", 1'b1, st.chip_rst_n);
    endtask : t_por

    task automatic wrap_up;
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    // Main sequence: power-up with the pin held, then the scenarios
    initial begin
        clk      = 1'b0;
        rst_req  = 1'b0;
        dbg      = 1'b0;
        pwr_bad  = 1'b0;
        strap_hi = 1'b0;
        pudr     = crpc_pkg::PUDR_RESET_VAL;
        // Assert both resets after time zero so every reset edge is seen
        #2;
        rst_req  = 1'b1;
        pwr_bad  = 1'b1;
        step(16);
        pwr_bad = 1'b0;
        step(POR + 2);
        t_pullup();
        t_boot(1'b0);
        t_boot(1'b1);
        dbg = 1'b1;
        t_boot(1'b0);
        dbg = 1'b0;
        t_async();
        t_por();
        wrap_up();
    end

    // Watchdog: the tests need about a hundred cycles
    initial begin
        #(40 * 2000);
        failures++;
        wrap_up();
    end
endmodule : crpc_top_bench
